// ---- common/aocr_pkg.sv ----
// aocr_pkg: constants and types of the adc output configuration register bank
// assumes an ahb-lite slave whose registers sit at byte address 4 * register index
package aocr_pkg;

   // ------------------------------------------------------------------
   // register map
   // ------------------------------------------------------------------
   localparam int NUM_REGS = 14;
   localparam int IDX_W = 14;

   // register indices as printed; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_DITHER_DISABLE_CTRL = 14'h0001;
   localparam logic [IDX_W-1:0] IDX_STATS_CHANNEL_SELECT = 14'h0002;
   localparam logic [IDX_W-1:0] IDX_LANE_BIT_ORDER = 14'h0003;
   localparam logic [IDX_W-1:0] IDX_LANE_SWAP = 14'h0004;
   localparam logic [IDX_W-1:0] IDX_LANE_COUNT_SELECT = 14'h0005;
   localparam logic [IDX_W-1:0] IDX_CHAN_B_SPECIAL_CTRL = 14'h0439;
   localparam logic [IDX_W-1:0] IDX_HIGH_FREQ_INPUT_CTRL_3 = 14'h051D;
   localparam logic [IDX_W-1:0] IDX_CHAN_C_CHOPPER_CTRL = 14'h0522;
   localparam logic [IDX_W-1:0] IDX_CHAN_C_DITHER_COMPANION = 14'h0534;
   localparam logic [IDX_W-1:0] IDX_CHAN_C_SPECIAL_CTRL = 14'h0539;
   localparam logic [IDX_W-1:0] IDX_HIGH_FREQ_INPUT_CTRL_HI = 14'h0608;
   localparam logic [IDX_W-1:0] IDX_HIGH_FREQ_INPUT_CTRL_5 = 14'h061D;
   localparam logic [IDX_W-1:0] IDX_SYNC_INPUT_POWERDOWN = 14'h070A;
   localparam logic [IDX_W-1:0] IDX_DC_LEVEL_FORCE_CTRL = 14'h071A;

   // slot inside the bank storage of each register that the logic decodes
   localparam int S_DITHER = 0;
   localparam int S_STATS = 1;
   localparam int S_ORDER = 2;
   localparam int S_SWAP = 3;
   localparam int S_LANES = 4;
   localparam int S_SYNC_PD = 12;
   localparam int S_DC_LEVEL_FORCE = 13;

   localparam logic [IDX_W-1:0] REG_INDEX [NUM_REGS] = '{
      IDX_DITHER_DISABLE_CTRL, IDX_STATS_CHANNEL_SELECT, IDX_LANE_BIT_ORDER,
      IDX_LANE_SWAP, IDX_LANE_COUNT_SELECT, IDX_CHAN_B_SPECIAL_CTRL,
      IDX_HIGH_FREQ_INPUT_CTRL_3, IDX_CHAN_C_CHOPPER_CTRL, IDX_CHAN_C_DITHER_COMPANION,
      IDX_CHAN_C_SPECIAL_CTRL, IDX_HIGH_FREQ_INPUT_CTRL_HI, IDX_HIGH_FREQ_INPUT_CTRL_5,
      IDX_SYNC_INPUT_POWERDOWN, IDX_DC_LEVEL_FORCE_CTRL};

   // bits that store a value; writes to all others are dropped and they read as zero
   localparam logic [7:0] REG_WMASK [NUM_REGS] = '{
      8'hFF, 8'hC0, 8'h01, 8'h01, 8'h01, 8'h08, 8'h02,
      8'h02, 8'h28, 8'h08, 8'hC0, 8'h82, 8'h01, 8'h0E};

   localparam logic [7:0] REG_RESET [NUM_REGS] = '{
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

   // ------------------------------------------------------------------
   // field positions and codes
   // ------------------------------------------------------------------
   localparam int DITHER_A_MSB = 7;
   localparam logic [1:0] DITHER_OFF_CODE = 2'h3;
   localparam int STATS_SEL_LSB = 6;
   localparam int ORDER_BIT = 0;
   localparam int SWAP_BIT = 0;
   localparam int LANES_BIT = 0;
   localparam int SYNC_PD_BIT = 0;
   localparam int DC_LEVEL_FORCE_LSB = 1;

   // ------------------------------------------------------------------
   // serial lanes
   // ------------------------------------------------------------------
   localparam int NUM_CH = 4;
   localparam int SAMPLE_W = 12;
   localparam logic [3:0] LAST_SLOT_TWO_WIRE = 4'h5;
   localparam logic [3:0] LAST_SLOT_ONE_WIRE = 4'hB;
   localparam logic [3:0] WIRE1_SEQ_START = 4'h7;
   localparam logic [3:0] WIRE1_SEQ_WRAP = 4'h5;
   localparam logic [3:0] WIRE1_LEFTOVER_BIT = 4'h6;

   // ------------------------------------------------------------------
   // bus
   // ------------------------------------------------------------------
   localparam logic [15:0] ADDR_HI_ZERO = 16'h0000;
   localparam logic HRESP_OKAY = 1'b0;

   typedef enum logic {SER_IDLE, SER_SHIFT} aocr_ser_state_t;

endpackage : aocr_pkg

// ---- common/aocr_ser_if.sv ----
// aocr_ser_if: carries one channel's sample, slot and lane setup to its serializer
// assumes the controller drives load for exactly one cycle per accepted sample
`timescale 1ns/1ps
interface aocr_ser_if;
   logic load;
   logic [11:0] sample;
   logic [3:0] slot;
   logic one_wire;
   logic odd_even;
   logic swap;
   logic lane0;
   logic lane1;

   modport ctl (output load, sample, slot, one_wire, odd_even, swap, input lane0, lane1);
   modport ser (input load, sample, slot, one_wire, odd_even, swap, output lane0, lane1);
endinterface : aocr_ser_if

// ---- core/aocr_lane_ser.sv ----
// aocr_lane_ser: holds one channel sample and drives its two output lanes per slot
// assumes slot steps by one each cycle and lane setup is steady for the whole frame
`timescale 1ns/1ps
module aocr_lane_ser
   import aocr_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // controller side
   aocr_ser_if.ser port
);

   typedef struct packed {
      logic [SAMPLE_W-1:0] sample;
      logic lane0;
      logic lane1;
   } aocr_ser_reg_t;

   aocr_ser_reg_t s_q;
   aocr_ser_reg_t s_d;

   always_comb begin
      logic b0;
      logic b1;
      s_d = s_q;
      b0 = 1'b0;
      b1 = 1'b0;
      if (port.one_wire) begin
         b0 = s_q.sample[port.slot];
      end else if (port.odd_even) begin
         b0 = s_q.sample[{port.slot[2:0], 1'b0}];
         b1 = s_q.sample[{port.slot[2:0], 1'b1}];
      end else begin
         b0 = s_q.sample[port.slot];
         // wire 1 runs from bit 7 upward; bit 6 closes the frame
         if (port.slot < WIRE1_SEQ_WRAP) begin
            b1 = s_q.sample[WIRE1_SEQ_START + port.slot];
         end else begin
            b1 = s_q.sample[WIRE1_LEFTOVER_BIT];
         end
      end
      // order and swap are ignored in one-wire mode
      if (port.swap && !port.one_wire) begin
         s_d.lane0 = b1;
         s_d.lane1 = b0;
      end else begin
         s_d.lane0 = b0;
         s_d.lane1 = b1;
      end
      if (port.load) begin
         s_d.sample = port.sample;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign port.lane0 = s_q.lane0;
   assign port.lane1 = s_q.lane1;

endmodule : aocr_lane_ser

// ---- core/aocr_top.sv ----
// aocr_top: output configuration register bank of a quad adc, with the lane serializers
// assumes a single ahb-lite master, whole-word single transfers, samples on REF_CLK
//
// Notes on behaviour
// - two-bit dither field per channel; code 11 switches that channel's dither off
// - statistics channel select at bits 7-6: 00 A through 11 D
// - order clear: wire 0 from bit 0 sequentially, wire 1 from bit 7
// - order set: even bits on wire 0, odd bits on wire 1
// - bit order only matters in two-wire mode
// - swap set exchanges each channel's lane 0 and lane 1 contents
// - swap only takes effect in two-wire mode
// - lane-count bit 0: each channel uses both lanes
// - lane-count bit 1: each channel uses only its first lane
`timescale 1ns/1ps
module aocr_top
   import aocr_pkg::*;
(
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RESET,
   // ahb-lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   // sample input, channel a in the low bits
   input wire logic SAMPLE_VALID,
   input wire logic [47:0] SAMPLE_DATA,
   output logic SAMPLE_READY,
   // serial lanes, bit 0 is channel a
   output logic [3:0] LANE0,
   output logic [3:0] LANE1,
   output logic LANE_VALID,
   output logic LANE_FRAME,
   // settings for the analog side
   output logic [3:0] DITHER_OFF,
   output logic [1:0] STATISTICS_CHANNEL_SELECT,
   output logic ONE_WIRE_MODE,
   output logic SYNC_INPUT_POWERDOWN,
   output logic [2:0] DC_LEVEL_FORCE
);

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [NUM_REGS-1:0][7:0] regs;
      logic [NUM_REGS-1:0] wsel;
      logic wr_pend;
      logic [31:0] rdata;
      logic readyout;
      aocr_ser_state_t state;
      logic [3:0] slot;
      logic [3:0] last_slot;
      logic one_wire;
      logic odd_even;
      logic swap;
      logic ready;
      logic valid;
      logic frame;
      logic [3:0] dither_off;
      logic [1:0] stats_sel;
      logic lanes_one;
      logic sync_pd;
      logic [2:0] dc_level_force;
   } aocr_top_reg_t;

   aocr_top_reg_t s_q;
   aocr_top_reg_t s_d;
   aocr_top_reg_t s_rst;
   logic ser_load;

   always_comb begin
      s_rst = '0;
      for (int i = 0; i < NUM_REGS; i++) begin
         s_rst.regs[i] = REG_RESET[i];
      end
      s_rst.readyout = 1'b1;
      s_rst.state = SER_IDLE;
      s_rst.ready = 1'b1;
   end

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb begin
      logic addr_ok;
      logic [7:0] rbyte;
      s_d = s_q;
      ser_load = 1'b0;
      addr_ok = HSEL && HREADY && HTRANS[1];
      rbyte = 8'h00;

      // data phase of a write: only storage bits take the value
      if (s_q.wr_pend) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            if (s_q.wsel[i]) begin
               s_d.regs[i] = HWDATA[7:0] & REG_WMASK[i];
            end
         end
      end

      // address phase: decode, and read from the updated bank
      s_d.wr_pend = 1'b0;
      s_d.wsel = '0;
      s_d.rdata = '0;
      if (addr_ok && HADDR[31:16] == ADDR_HI_ZERO) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            if (HADDR[15:2] == REG_INDEX[i]) begin
               s_d.wsel[i] = 1'b1;
               rbyte = rbyte | s_d.regs[i];
            end
         end
      end
      if (addr_ok && HWRITE) begin
         s_d.wr_pend = |s_d.wsel;
      end
      if (addr_ok && !HWRITE) begin
         s_d.rdata = {24'h00_0000, rbyte};
      end
      s_d.readyout = 1'b1;

      // frame sequencing shared by all four channels
      s_d.valid = (s_q.state == SER_SHIFT);
      s_d.frame = (s_q.state == SER_SHIFT) && (s_q.slot == 4'h0);
      unique case (s_q.state)
         SER_IDLE: begin
            s_d.ready = 1'b1;
         end
         SER_SHIFT: begin
            s_d.slot = s_q.slot + 4'h1;
            if (s_q.slot == s_q.last_slot - 4'h1) begin
               s_d.ready = 1'b1;
            end
            if (s_q.slot == s_q.last_slot) begin
               s_d.state = SER_IDLE;
               s_d.ready = 1'b1;
            end
         end
      endcase
      // ready rises one slot early so frames run back to back
      if (SAMPLE_VALID && s_q.ready) begin
         ser_load = 1'b1;
         s_d.state = SER_SHIFT;
         s_d.slot = 4'h0;
         s_d.ready = 1'b0;
         // lane setup is frozen per frame so a write cannot tear one
         s_d.one_wire = s_q.regs[S_LANES][LANES_BIT];
         s_d.odd_even = s_q.regs[S_ORDER][ORDER_BIT];
         s_d.swap = s_q.regs[S_SWAP][SWAP_BIT];
         if (s_q.regs[S_LANES][LANES_BIT]) begin
            s_d.last_slot = LAST_SLOT_ONE_WIRE;
         end else begin
            s_d.last_slot = LAST_SLOT_TWO_WIRE;
         end
      end

      // decoded settings
      for (int c = 0; c < NUM_CH; c++) begin
         s_d.dither_off[c] =
            (s_d.regs[S_DITHER][DITHER_A_MSB-2*c -: 2] == DITHER_OFF_CODE);
      end
      s_d.stats_sel = s_d.regs[S_STATS][STATS_SEL_LSB +: 2];
      s_d.lanes_one = s_d.regs[S_LANES][LANES_BIT];
      s_d.sync_pd = s_d.regs[S_SYNC_PD][SYNC_PD_BIT];
      s_d.dc_level_force = s_d.regs[S_DC_LEVEL_FORCE][DC_LEVEL_FORCE_LSB +: 3];
   end

   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         s_q <= s_rst;
      end else begin
         s_q <= s_d;
      end
   end

   // ------------------------------------------------------------------
   // per-channel serializers
   // ------------------------------------------------------------------
   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      aocr_ser_if sif();
      assign sif.load = ser_load;
      assign sif.sample = SAMPLE_DATA[c*SAMPLE_W +: SAMPLE_W];
      assign sif.slot = s_q.slot;
      assign sif.one_wire = s_q.one_wire;
      assign sif.odd_even = s_q.odd_even;
      assign sif.swap = s_q.swap;
      aocr_lane_ser u_ser (
         .clk(REF_CLK),
         .rst(RESET),
         .port(sif)
      );
      assign LANE0[c] = sif.lane0;
      assign LANE1[c] = sif.lane1;
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   assign HRDATA = s_q.rdata;
   assign HREADYOUT = s_q.readyout;
   assign HRESP = HRESP_OKAY;
   assign SAMPLE_READY = s_q.ready;
   assign LANE_VALID = s_q.valid;
   assign LANE_FRAME = s_q.frame;
   assign DITHER_OFF = s_q.dither_off;
   assign STATISTICS_CHANNEL_SELECT = s_q.stats_sel;
   assign ONE_WIRE_MODE = s_q.lanes_one;
   assign SYNC_INPUT_POWERDOWN = s_q.sync_pd;
   assign DC_LEVEL_FORCE = s_q.dc_level_force;

endmodule : aocr_top

// ---- tb/aocr_lane_partner.sv ----
// aocr_lane_partner: sample source and lane receiver facing aocr_top
// assumes go is raised only while no sample is pending
`timescale 1ns/1ps
module aocr_lane_partner (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // bench side
   input wire logic go,
   input wire logic [47:0] word,
   output logic [3:0] cap0 [12],
   output logic [3:0] cap1 [12],
   output logic [4:0] n_slots,
   output logic [7:0] frames,
   // device side
   output logic sample_valid,
   output logic [47:0] sample_data,
   input wire logic sample_ready,
   input wire logic [3:0] lane0,
   input wire logic [3:0] lane1,
   input wire logic lane_valid,
   input wire logic lane_frame
);
   logic lv_q;
   initial begin
      sample_valid = 1'b0;
      sample_data = 48'h0000_0000_0000;
   end
   always @(posedge clk) begin
      lv_q <= lane_valid;
      if (rst) begin
         sample_valid <= 1'b0;
         frames <= 8'h00;
         n_slots <= 5'h00;
      end else begin
         // go held a second cycle offers the next sample at once: back-to-back frames
         if (go) begin
            sample_valid <= 1'b1;
            sample_data <= word;
         end else if (sample_valid && sample_ready) begin
            sample_valid <= 1'b0;
            // released data must not keep looking like the sample
            sample_data <= ~sample_data;
         end
         if (lane_valid) begin
            cap0[lane_frame ? 4'h0 : n_slots[3:0]] <= lane0;
            cap1[lane_frame ? 4'h0 : n_slots[3:0]] <= lane1;
            n_slots <= lane_frame ? 5'h01 : n_slots + 5'h01;
         end
         if (lv_q && !lane_valid) frames <= frames + 8'h01;
      end
   end
endmodule : aocr_lane_partner

// ---- tb/aocr_top_asserts.sv ----
// aocr_top_asserts: concurrent checks on the ports of aocr_top
// assumes HREADY is HREADYOUT looped back and lane setup changes only between frames
`timescale 1ns/1ps
module aocr_top_asserts (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RESET,
   // bus
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   input wire logic [31:0] HRDATA,
   input wire logic HREADYOUT,
   input wire logic HRESP,
   // samples and lanes
   input wire logic SAMPLE_VALID,
   input wire logic SAMPLE_READY,
   input wire logic [3:0] LANE1,
   input wire logic LANE_VALID,
   input wire logic LANE_FRAME,
   // settings
   input wire logic [3:0] DITHER_OFF,
   input wire logic [1:0] STATISTICS_CHANNEL_SELECT,
   input wire logic ONE_WIRE_MODE
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RESET);
   // write taken; setting shows one cycle after the data phase
   sequence wr_at(logic [31:0] a);
      HSEL && HREADY && HTRANS[1] && HWRITE && HADDR == a;
   endsequence
   bus_okay_a: assert property (HREADYOUT == 1'b1 && HRESP == 1'b0)
      else $error("bus not ready or not okay");
   unmapped_read_a: assert property (HSEL && HREADY && HTRANS[1] && !HWRITE &&
      HADDR[31:16] != 16'h0000 |=> HRDATA == 32'h0000_0000) else $error("unmapped read data");
   dither_write_a: assert property (wr_at(32'h0000_0004) ##1 1'b1 |=> DITHER_OFF == {
      &$past(HWDATA[1:0]), &$past(HWDATA[3:2]), &$past(HWDATA[5:4]), &$past(HWDATA[7:6])})
      else $error("dither off mismatch");
   stats_write_a: assert property (wr_at(32'h0000_0008) ##1 1'b1 |=>
      STATISTICS_CHANNEL_SELECT == $past(HWDATA[7:6])) else $error("stats select mismatch");
   lane_count_a: assert property (wr_at(32'h0000_0014) ##1 1'b1 |=>
      ONE_WIRE_MODE == $past(HWDATA[0])) else $error("lane count mismatch");
   take_frame_a: assert property (SAMPLE_VALID && SAMPLE_READY |=> !SAMPLE_READY ##1
      (LANE_FRAME && LANE_VALID)) else $error("frame not two cycles after take");
   two_wire_len_a: assert property (LANE_FRAME && !ONE_WIRE_MODE |-> LANE_VALID[*6] ##1
      (!LANE_VALID || LANE_FRAME)) else $error("two-wire frame length");
   one_wire_len_a: assert property (LANE_FRAME && ONE_WIRE_MODE |-> LANE_VALID[*8] ##1
      (LANE_VALID && !LANE_FRAME)[*4] ##1 (!LANE_VALID || LANE_FRAME))
      else $error("one-wire frame length");
   lane_one_idle_a: assert property (LANE_FRAME && ONE_WIRE_MODE |-> LANE1 == 4'h0)
      else $error("lane one busy in one-wire mode");
   cover property (LANE_FRAME && ONE_WIRE_MODE);
   cover property (LANE_FRAME && !ONE_WIRE_MODE);
   cover property (wr_at(32'h0000_0004));
endmodule : aocr_top_asserts

bind aocr_top aocr_top_asserts u_chk (.REF_CLK(REF_CLK), .RESET(RESET), .HSEL(HSEL),
   .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
   .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SAMPLE_VALID(SAMPLE_VALID),
   .SAMPLE_READY(SAMPLE_READY), .LANE1(LANE1), .LANE_VALID(LANE_VALID),
   .LANE_FRAME(LANE_FRAME), .DITHER_OFF(DITHER_OFF),
   .STATISTICS_CHANNEL_SELECT(STATISTICS_CHANNEL_SELECT), .ONE_WIRE_MODE(ONE_WIRE_MODE));

// ---- tb/test_adc_output_config_regs.sv ----
// test_adc_output_config_regs: register and lane tests of aocr_top over ahb-lite
// assumes a zero-wait slave but always waits on HREADYOUT; the partner feeds samples
`timescale 1ns/1ps
module test_adc_output_config_regs
   import aocr_pkg::*;
;
   logic ref_clk, reset, hsel, hwrite, hreadyout, hresp, go, sv, sr, lv, lf, ow, spd;
   logic [1:0] htrans, stats;
   logic [2:0] dcf;
   logic [3:0] l0, l1, dith;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [47:0] sd, word;
   logic [3:0] cap0 [12];
   logic [3:0] cap1 [12];
   logic [4:0] n_slots;
   logic [7:0] frames;
   int failures, check_count, cyc;
   aocr_top dut (.REF_CLK(ref_clk), .RESET(reset), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
      .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .SAMPLE_VALID(sv),
      .SAMPLE_DATA(sd), .SAMPLE_READY(sr), .LANE0(l0), .LANE1(l1), .LANE_VALID(lv),
      .LANE_FRAME(lf), .DITHER_OFF(dith), .STATISTICS_CHANNEL_SELECT(stats),
      .ONE_WIRE_MODE(ow), .SYNC_INPUT_POWERDOWN(spd), .DC_LEVEL_FORCE(dcf));
   aocr_lane_partner u_partner (.clk(ref_clk), .rst(reset), .go(go), .word(word),
      .cap0(cap0), .cap1(cap1), .n_slots(n_slots), .frames(frames), .sample_valid(sv),
      .sample_data(sd), .sample_ready(sr), .lane0(l0), .lane1(l1), .lane_valid(lv),
      .lane_frame(lf));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic end_sim();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : end_sim
   // whole run needs well under two thousand cycles
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         end_sim();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // hready and read data are taken at the rising edge, before the slave updates them
   task automatic wait_rdy();
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : wait_rdy
   task automatic bus(input logic wr, input logic [31:0] a, input logic [7:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= {24'h00_0000, d};
      wait_rdy();
   endtask : bus
   // returns {lane one, lane zero} of slot k for mode {one wire, odd even, swap}
   function automatic logic [1:0] lane_bits(input logic [11:0] s, input int k,
      input logic [2:0] m);
      logic a, b;
      a = m[1] ? s[2*k] : s[k];
      b = m[1] ? s[2*k+1] : (k < 5 ? s[7+k] : s[6]);
      if (m[2]) return {1'b0, s[k]};
      return m[0] ? {a, b} : {b, a};
   endfunction : lane_bits
   logic [2:0] md [6] = '{3'h0, 3'h2, 3'h1, 3'h3, 3'h7, 3'h4};
   logic [7:0] dv [5] = '{8'hC0, 8'h30, 8'h0C, 8'h03, 8'h80};
   logic [3:0] de [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h0};
   initial begin
      logic [3:0] e0, e1;
      logic [1:0] e;
      logic [7:0] nf;
      reset = 1'b1;
      hsel = 1'b0;
      htrans = 2'h0;
      haddr = 32'h0000_0000;
      hwrite = 1'b0;
      hwdata = 32'h0000_0000;
      go = 1'b0;
      word = 48'h3C96_A1F0_EA5C;
      repeat (20) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      for (int i = 0; i < NUM_REGS; i++) begin
         bus(1'b0, {16'h0000, REG_INDEX[i], 2'h0}, 8'h00);
         chk(rd, 32'h0000_0000);
         bus(1'b1, {16'h0000, REG_INDEX[i], 2'h0}, 8'hFF);
         bus(1'b0, {16'h0000, REG_INDEX[i], 2'h0}, 8'h00);
         chk(rd, {24'h00_0000, REG_WMASK[i]});
      end
      chk({dith, stats, ow, spd, dcf}, 32'h0000_07FF);
      for (int i = 0; i < NUM_REGS; i++) bus(1'b1, {16'h0000, REG_INDEX[i], 2'h0}, 8'h00);
      // settings flop at the edge that ends the write, so look one edge later
      @(posedge ref_clk);
      chk({dith, stats, ow, spd, dcf}, 32'h0000_0000);
      bus(1'b1, 32'h0001_0004, 8'hFF);
      bus(1'b0, 32'h0001_0004, 8'h00);
      chk(rd, 32'h0000_0000);
      bus(1'b0, 32'h0000_0004, 8'h00);
      chk(rd, 32'h0000_0000);
      for (int i = 0; i < 5; i++) begin
         bus(1'b1, 32'h0000_0004, dv[i]);
         bus(1'b1, 32'h0000_14D0, (dv[i][3:2] == 2'h3) ? 8'h28 : 8'h00);
         bus(1'b1, 32'h0000_0008, {i[1:0], 6'h00});
         @(posedge ref_clk);
         chk(dith, de[i]);
         chk(stats, i[1:0]);
      end
      for (int i = 0; i < 6; i++) begin
         bus(1'b1, 32'h0000_000C, {7'h00, md[i][1]});
         bus(1'b1, 32'h0000_0010, {7'h00, md[i][0]});
         bus(1'b1, 32'h0000_0014, {7'h00, md[i][2]});
         word <= word + 48'h0111_1111_1111;
         nf = frames;
         go <= 1'b1;
         repeat (2) @(posedge ref_clk);
         go <= 1'b0;
         for (int t = 0; t < 60 && frames == nf; t++) @(posedge ref_clk);
         chk(n_slots, md[i][2] ? 32'h0000_000C : 32'h0000_0006);
         for (int k = 0; k < (md[i][2] ? 12 : 6); k++) begin
            for (int c = 0; c < 4; c++) begin
               e = lane_bits(word[c*12 +: 12], k, md[i]);
               e0[c] = e[0];
               e1[c] = e[1];
            end
            chk({cap1[k], cap0[k]}, {e1, e0});
         end
      end
      // a reset in mid-run clears every setting and the frame state again
      bus(1'b1, 32'h0000_0004, 8'hFF);
      reset <= 1'b1;
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      chk({dith, stats, ow, spd, dcf}, 32'h0000_0000);
      chk({sr, lv, lf}, 32'h0000_0004);
      bus(1'b0, 32'h0000_0004, 8'h00);
      chk(rd, 32'h0000_0000);
      end_sim();
   end
endmodule : test_adc_output_config_regs
